// >>> rtl/ugxc_consts.vh
// Purpose: Constants for the GPIO and extra control register bank
// Assumes: Register indices are locally assigned
// Notes: Included by ugxc_regs.v
`ifndef UGXC_CONSTS_VH
`define UGXC_CONSTS_VH
`define UGXC_ADDR_W 4
`define UGXC_A_DIR 4'h0
`define UGXC_A_LEVEL 4'h1
`define UGXC_A_IRQEN 4'h2
`define UGXC_A_FUNC 4'h3
`define UGXC_A_EXTRA 4'h4
`define UGXC_A_DIVL 4'h5
`define UGXC_A_DIVH 4'h6
`define UGXC_A_FRAC 4'h7
`define UGXC_A_ENH 4'h8
`define UGXC_A_RES1 4'h9
`define UGXC_A_RES2 4'hA
`define UGXC_A_PAU1 4'hB
`define UGXC_A_PAU2 4'hC
`define UGXC_A_SCRATCH 4'hD
`define UGXC_A_STATUS 4'hE
`define UGXC_FUNC_LATCH 0
`define UGXC_FUNC_MODEM_A 1
`define UGXC_FUNC_MODEM_B 2
`define UGXC_FUNC_SWRST 3
`define UGXC_EXTRA_RXDIS 1
`define UGXC_EXTRA_TXDIS 2
`define UGXC_EXTRA_IRFAST 7
`define UGXC_EXTRA_MASK 8'h86
`define UGXC_FUNC_MASK 8'h07
`define UGXC_FRAC_MASK 8'h3F
`define UGXC_ENH_EN 4
`define UGXC_ZERO8 8'h00
`define UGXC_DIVL_PWRUP 8'h01
`define UGXC_SCRATCH_PWRUP 8'hFF
`define UGXC_OS_16X 2'h0
`define UGXC_OS_8X 2'h1
`define UGXC_OS_4X 2'h2
`define UGXC_FC_NONE 2'h0
`define UGXC_FC_SECOND 2'h1
`define UGXC_FC_FIRST 2'h2
`define UGXC_FC_BOTH 2'h3
`define UGXC_SWRST_CYCLES 4'h4
`endif

// >>> rtl/ugxc_regs.v
// Purpose: GPIO, modem pin select and extra control register bank of a UART
// Assumes: One clock, synchronous active-low reset, simple strobe register port
// Notes: Pin inputs pass two flip-flops before use
//
// Behaviour
// - Level register reads pins, writes drive outputs
// - Per-pin enable gates change interrupt
// - Pins 7-4 enables ignored in modem A
// - Software reset bit self-clears after reset
// - Bit 2 makes pins 3-0 modem B
// - Bit 1 makes pins 7-4 modem A
// - Unlatched: change flags, revert or read clears
// - Latched: level and flag held until read
// - Extra bit 7 selects infrared pulse width
// - Transmit disable after current character completes
// - Receive disable, current character still stored
// - Divisor is high:low plus fraction/16
// - Fraction register needs enhanced enable
// - Fraction bits 5:4 select oversampling
// - Enhanced bits 3:2 select transmit flow
// - Enhanced bits 1:0 select receive compare
// - Dual mode pairs characters as sequence
// - Enhanced disable freezes fraction bits
// - Software reset spares divisor, scratch, characters
`timescale 1ns/10ps
`include "ugxc_consts.vh"

module ugxc_regs #(
	parameter PINS = 8
) (
	input wire sys_clk,
	input wire rstn,
	input wire [`UGXC_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [PINS-1:0] gpio_in,
	output wire [PINS-1:0] gpio_out,
	output wire [PINS-1:0] gpio_oe,
	input wire chan_a_terminal_ready_n,
	input wire chan_b_terminal_ready_n,
	output wire chan_a_ring_indicator_n,
	output wire chan_a_carrier_detect_n,
	output wire chan_a_set_ready_n,
	output wire chan_b_ring_indicator_n,
	output wire chan_b_carrier_detect_n,
	output wire chan_b_set_ready_n,
	input wire other_irq,
	output wire irq_n,
	output wire uart_soft_reset,
	output wire tx_disable,
	output wire rx_disable,
	output wire ir_fast_pulse,
	output wire [15:0] baud_int,
	output wire [3:0] baud_frac,
	output reg [1:0] oversample_sel,
	output wire [1:0] tx_flow_sel,
	output wire [1:0] rx_flow_sel,
	output wire rx_either_pair,
	output wire rx_dual_seq,
	output wire tx_dual_seq,
	output wire [7:0] resume_char_first,
	output wire [7:0] resume_char_second,
	output wire [7:0] pause_char_first,
	output wire [7:0] pause_char_second
);

// ----------------------------------------
// Storage
// ----------------------------------------
reg [PINS-1:0] gpio_direction_reg;
reg [PINS-1:0] gpio_out_reg;
reg [PINS-1:0] gpio_change_irq_enable_reg;
reg [7:0] gpio_function_control_reg;
reg [7:0] extra_feature_control_reg;
reg [7:0] baud_divisor_low_reg;
reg [7:0] baud_divisor_high_reg;
reg [7:0] baud_fraction_and_sampling_reg;
reg [7:0] enhanced_feature_control_reg;
reg [7:0] res1_reg;
reg [7:0] res2_reg;
reg [7:0] pau1_reg;
reg [7:0] pau2_reg;
reg [7:0] scratch_reg;
// Starts low so the first edge after power-on loads the power-up values
reg pwrup_done_reg = 1'h0;
reg [3:0] swrst_cnt_reg;
reg [PINS-1:0] sync1_reg;
reg [PINS-1:0] sync2_reg;
reg [PINS-1:0] base_reg;
reg [PINS-1:0] latched_reg;
reg [PINS-1:0] pend_reg;
reg [PINS-1:0] pend_next;
reg [PINS-1:0] latched_next;
reg [PINS-1:0] base_next;
reg [7:0] rdata_next;
reg [PINS-1:0] gpio_mask;
reg [PINS-1:0] change;
integer i;

wire enh_en = enhanced_feature_control_reg[`UGXC_ENH_EN];
wire latch_on = gpio_function_control_reg[`UGXC_FUNC_LATCH];
wire modem_a = gpio_function_control_reg[`UGXC_FUNC_MODEM_A];
wire modem_b = gpio_function_control_reg[`UGXC_FUNC_MODEM_B];
wire swrst = gpio_function_control_reg[`UGXC_FUNC_SWRST];
wire any_rst = !rstn || swrst;
wire wr_func = reg_wr && reg_addr == `UGXC_A_FUNC;
wire rd_level = reg_rd && reg_addr == `UGXC_A_LEVEL;

// ----------------------------------------
// Pin synchroniser
// ----------------------------------------
always @(posedge sys_clk) begin
	sync1_reg <= gpio_in;
	sync2_reg <= sync1_reg;
end

// ----------------------------------------
// Pin roles
// ----------------------------------------
always @* begin
	gpio_mask = {PINS{1'b1}};
	if (modem_b) begin
		gpio_mask[3:0] = 4'h0;
	end
	if (modem_a) begin
		gpio_mask[7:4] = 4'h0;
	end
end

// Modem B: 3 ring, 2 carrier, 1 terminal ready, 0 set ready; A likewise on 7-4
assign chan_b_ring_indicator_n = sync2_reg[3];
assign chan_b_carrier_detect_n = sync2_reg[2];
assign chan_b_set_ready_n = sync2_reg[0];
assign chan_a_ring_indicator_n = sync2_reg[7];
assign chan_a_carrier_detect_n = sync2_reg[6];
assign chan_a_set_ready_n = sync2_reg[4];

reg [PINS-1:0] out_mux;
always @* begin
	out_mux = gpio_out_reg;
	if (modem_b) begin
		out_mux[1] = chan_b_terminal_ready_n;
	end
	if (modem_a) begin
		out_mux[5] = chan_a_terminal_ready_n;
	end
end
assign gpio_out = out_mux;
assign gpio_oe = gpio_direction_reg;

// ----------------------------------------
// Change detection
// ----------------------------------------
always @* begin
	pend_next = pend_reg;
	latched_next = latched_reg;
	base_next = base_reg;
	change = (sync2_reg ^ base_reg) & ~gpio_direction_reg & gpio_mask;
	if (rd_level) begin
		pend_next = {PINS{1'b0}};
		base_next = sync2_reg;
		latched_next = sync2_reg;
	end
	for (i = 0; i < PINS; i = i + 1) begin
		if (latch_on) begin
			if (change[i] && !pend_reg[i]) begin
				pend_next[i] = 1'b1;
				latched_next[i] = sync2_reg[i];
			end
		end else begin
			pend_next[i] = change[i] & !rd_level;
			if (!change[i] && !rd_level) begin
				pend_next[i] = 1'b0;
			end
		end
	end
end

wire [PINS-1:0] level_view;
assign level_view = latch_on ? ((latched_reg & pend_reg) | (sync2_reg & ~pend_reg)) : sync2_reg;

wire [PINS-1:0] irq_gate;
assign irq_gate = gpio_change_irq_enable_reg & gpio_mask;
assign irq_n = !((|(pend_reg & irq_gate)) || other_irq);

// ----------------------------------------
// Register writes
// ----------------------------------------
always @(posedge sys_clk) begin
	if (any_rst) begin
		gpio_direction_reg <= {PINS{1'b0}};
		gpio_out_reg <= {PINS{1'b0}};
		gpio_change_irq_enable_reg <= {PINS{1'b0}};
		extra_feature_control_reg <= `UGXC_ZERO8;
		baud_fraction_and_sampling_reg <= `UGXC_ZERO8;
		enhanced_feature_control_reg <= `UGXC_ZERO8;
		pend_reg <= {PINS{1'b0}};
		latched_reg <= {PINS{1'b0}};
		base_reg <= sync2_reg;
	end else begin
		pend_reg <= pend_next;
		latched_reg <= latched_next;
		base_reg <= latch_on ? base_next : (rd_level ? sync2_reg : base_reg);
		if (reg_wr) begin
			case (reg_addr)
				`UGXC_A_DIR: gpio_direction_reg <= reg_wdata[PINS-1:0];
				`UGXC_A_LEVEL: gpio_out_reg <= reg_wdata[PINS-1:0];
				`UGXC_A_IRQEN: gpio_change_irq_enable_reg <= reg_wdata[PINS-1:0];
				`UGXC_A_EXTRA: begin
					extra_feature_control_reg <= reg_wdata & `UGXC_EXTRA_MASK;
				end
				`UGXC_A_FRAC: begin
					if (enh_en) begin
						baud_fraction_and_sampling_reg <= reg_wdata & `UGXC_FRAC_MASK;
					end
				end
				`UGXC_A_ENH: enhanced_feature_control_reg <= reg_wdata;
				default: begin
				end
			endcase
		end
	end
end

// Power-up only values, untouched by the software reset
always @(posedge sys_clk) begin
	if (!pwrup_done_reg) begin
		pwrup_done_reg <= 1'b1;
		baud_divisor_low_reg <= `UGXC_DIVL_PWRUP;
		baud_divisor_high_reg <= `UGXC_ZERO8;
		scratch_reg <= `UGXC_SCRATCH_PWRUP;
		res1_reg <= `UGXC_ZERO8;
		res2_reg <= `UGXC_ZERO8;
		pau1_reg <= `UGXC_ZERO8;
		pau2_reg <= `UGXC_ZERO8;
	end else if (reg_wr) begin
		case (reg_addr)
			`UGXC_A_DIVL: baud_divisor_low_reg <= reg_wdata;
			`UGXC_A_DIVH: baud_divisor_high_reg <= reg_wdata;
			`UGXC_A_RES1: res1_reg <= reg_wdata;
			`UGXC_A_RES2: res2_reg <= reg_wdata;
			`UGXC_A_PAU1: pau1_reg <= reg_wdata;
			`UGXC_A_PAU2: pau2_reg <= reg_wdata;
			`UGXC_A_SCRATCH: scratch_reg <= reg_wdata;
			default: begin
			end
		endcase
	end
end

// ----------------------------------------
// Software reset sequencing
// ----------------------------------------
always @(posedge sys_clk) begin
	if (!rstn) begin
		gpio_function_control_reg <= `UGXC_ZERO8;
		swrst_cnt_reg <= 4'h0;
	end else if (swrst) begin
		swrst_cnt_reg <= swrst_cnt_reg + 4'h1;
		if (swrst_cnt_reg == `UGXC_SWRST_CYCLES - 4'h1) begin
			gpio_function_control_reg <= `UGXC_ZERO8;
			swrst_cnt_reg <= 4'h0;
		end
	end else if (wr_func) begin
		gpio_function_control_reg <= reg_wdata & {4'h0, 4'hF};
	end
end
assign uart_soft_reset = swrst;

// ----------------------------------------
// Derived controls
// ----------------------------------------
assign tx_disable = extra_feature_control_reg[`UGXC_EXTRA_TXDIS];
assign rx_disable = extra_feature_control_reg[`UGXC_EXTRA_RXDIS];
assign ir_fast_pulse = extra_feature_control_reg[`UGXC_EXTRA_IRFAST];
assign baud_int = {baud_divisor_high_reg, baud_divisor_low_reg};
assign baud_frac = baud_fraction_and_sampling_reg[3:0];

always @* begin
	if (baud_fraction_and_sampling_reg[5]) begin
		oversample_sel = `UGXC_OS_4X;
	end else if (baud_fraction_and_sampling_reg[4]) begin
		oversample_sel = `UGXC_OS_8X;
	end else begin
		oversample_sel = `UGXC_OS_16X;
	end
end

assign tx_flow_sel = enhanced_feature_control_reg[3:2];
assign rx_flow_sel = enhanced_feature_control_reg[1:0];
assign tx_dual_seq = tx_flow_sel == `UGXC_FC_BOTH;
assign rx_either_pair = rx_flow_sel == `UGXC_FC_BOTH &&
	(tx_flow_sel == `UGXC_FC_FIRST || tx_flow_sel == `UGXC_FC_SECOND);
assign rx_dual_seq = rx_flow_sel == `UGXC_FC_BOTH && !rx_either_pair;
assign resume_char_first = res1_reg;
assign resume_char_second = res2_reg;
assign pause_char_first = pau1_reg;
assign pause_char_second = pau2_reg;

// ----------------------------------------
// Read port
// ----------------------------------------
always @* begin
	rdata_next = `UGXC_ZERO8;
	case (reg_addr)
		`UGXC_A_DIR: rdata_next = gpio_direction_reg;
		`UGXC_A_LEVEL: rdata_next = level_view;
		`UGXC_A_IRQEN: rdata_next = gpio_change_irq_enable_reg;
		`UGXC_A_FUNC: rdata_next = gpio_function_control_reg;
		`UGXC_A_EXTRA: rdata_next = extra_feature_control_reg;
		`UGXC_A_DIVL: rdata_next = baud_divisor_low_reg;
		`UGXC_A_DIVH: rdata_next = baud_divisor_high_reg;
		`UGXC_A_FRAC: rdata_next = enh_en ? baud_fraction_and_sampling_reg : `UGXC_ZERO8;
		`UGXC_A_ENH: rdata_next = enhanced_feature_control_reg;
		`UGXC_A_RES1: rdata_next = res1_reg;
		`UGXC_A_RES2: rdata_next = res2_reg;
		`UGXC_A_PAU1: rdata_next = pau1_reg;
		`UGXC_A_PAU2: rdata_next = pau2_reg;
		`UGXC_A_SCRATCH: rdata_next = scratch_reg;
		`UGXC_A_STATUS: rdata_next = pend_reg;
		default: rdata_next = `UGXC_ZERO8;
	endcase
end

always @(posedge sys_clk) begin
	if (!rstn) begin
		reg_rdata <= `UGXC_ZERO8;
	end else if (reg_rd) begin
		reg_rdata <= rdata_next;
	end
end

endmodule // ugxc_regs

// >>> bench/ugxc_regs_sva.sv
// Purpose: Port assertions for the GPIO and extra control register bank
// Assumes: Register indices from ugxc_consts.vh
// Notes: Bound to every ugxc_regs instance
`timescale 1ns/10ps
`include "ugxc_consts.vh"

module ugxc_regs_sva (
	input wire sys_clk,
	input wire rstn,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire [7:0] gpio_out,
	input wire [7:0] gpio_oe,
	input wire other_irq,
	input wire irq_n,
	input wire uart_soft_reset,
	input wire tx_disable,
	input wire rx_disable,
	input wire ir_fast_pulse,
	input wire [15:0] baud_int,
	input wire [3:0] baud_frac,
	input wire [1:0] tx_flow_sel,
	input wire [1:0] rx_flow_sel,
	input wire rx_either_pair,
	input wire rx_dual_seq,
	input wire tx_dual_seq,
	input wire [7:0] resume_char_first
);
// ----------------------------------------
// Helpers
// ----------------------------------------
wire wr_func = reg_wr && reg_addr == `UGXC_A_FUNC;
wire go_rst = wr_func && reg_wdata[3];
wire wr_frac = reg_wr && reg_addr == `UGXC_A_FRAC;
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rstn);
sequence s_rst_run;
	uart_soft_reset [*4] ##1 !uart_soft_reset;
endsequence
// ----------------------------------------
// Properties
// ----------------------------------------
a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
	else $error("read data moved without a read");
a_dir_oe: assert property (reg_wr && reg_addr == `UGXC_A_DIR |=> gpio_oe == $past(reg_wdata))
	else $error("direction not on output enables");
a_level_out: assert property (reg_wr && reg_addr == `UGXC_A_LEVEL
	|=> ((gpio_out ^ $past(reg_wdata)) & 8'hDD) == 8'h00)
	else $error("pin drive differs from level write");
a_rst_run: assert property (go_rst && !uart_soft_reset |=> s_rst_run)
	else $error("software reset run wrong");
a_rst_cause: assert property ($rose(uart_soft_reset) |-> $past(go_rst))
	else $error("software reset without request");
a_irq_other: assert property (other_irq |-> !irq_n)
	else $error("other interrupt not merged");
a_extra_bits: assert property (reg_wr && reg_addr == `UGXC_A_EXTRA && !uart_soft_reset
	|=> {ir_fast_pulse, 4'h0, tx_disable, rx_disable, 1'h0} == ($past(reg_wdata) & 8'h86))
	else $error("extra control bits wrong");
a_div_high: assert property (reg_wr && reg_addr == `UGXC_A_DIVH
	|=> baud_int[15:8] == $past(reg_wdata))
	else $error("divisor high byte wrong");
a_frac_frozen: assert property (!$past(wr_frac) && !$past(uart_soft_reset) && !uart_soft_reset
	|-> $stable(baud_frac))
	else $error("fraction changed without write");
a_flow_decode: assert property (tx_dual_seq == (tx_flow_sel == 2'h3)
	&& rx_dual_seq == (rx_flow_sel == 2'h3 && tx_flow_sel[0] == tx_flow_sel[1])
	&& rx_either_pair == (rx_flow_sel == 2'h3 && tx_flow_sel[0] != tx_flow_sel[1]))
	else $error("flow control decode wrong");
a_rst_spares: assert property ($rose(uart_soft_reset)
	|-> ##4 baud_int == $past(baud_int, 5) && resume_char_first == $past(resume_char_first, 5))
	else $error("software reset cleared kept registers");
endmodule // ugxc_regs_sva

bind ugxc_regs ugxc_regs_sva u_sva (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.gpio_out(gpio_out), .gpio_oe(gpio_oe), .other_irq(other_irq), .irq_n(irq_n),
	.uart_soft_reset(uart_soft_reset), .tx_disable(tx_disable), .rx_disable(rx_disable),
	.ir_fast_pulse(ir_fast_pulse), .baud_int(baud_int), .baud_frac(baud_frac),
	.tx_flow_sel(tx_flow_sel), .rx_flow_sel(rx_flow_sel), .rx_either_pair(rx_either_pair),
	.rx_dual_seq(rx_dual_seq), .tx_dual_seq(tx_dual_seq), .resume_char_first(resume_char_first));

// >>> bench/ugxc_regs_bench.sv
// Purpose: Self-checking bench for the GPIO and extra control register bank
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes: Table of register round trips, then hand-written cases
`timescale 1ns/10ps
`include "ugxc_consts.vh"

module ugxc_regs_bench;
reg sys_clk, rstn, reg_wr, reg_rd, other_irq, tra_n, trb_n;
reg [3:0] reg_addr, k;
reg [7:0] reg_wdata, gpio_in;
reg [19:0] rows [0:16];
integer i, n, miscompares, tests_run;
wire [7:0] reg_rdata, gpio_out, gpio_oe, rc1, rc2, pc1, pc2;
wire ria_n, cda_n, sra_n, rib_n, cdb_n, srb_n, irq_n, srst, txd, rxd, irf, rxe, rxds, txds;
wire [15:0] baud_int;
wire [3:0] baud_frac;
wire [1:0] os, txf, rxf;
ugxc_regs DUT (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_in(gpio_in),
	.gpio_out(gpio_out), .gpio_oe(gpio_oe), .chan_a_terminal_ready_n(tra_n),
	.chan_b_terminal_ready_n(trb_n), .chan_a_ring_indicator_n(ria_n),
	.chan_a_carrier_detect_n(cda_n), .chan_a_set_ready_n(sra_n), .chan_b_ring_indicator_n(rib_n),
	.chan_b_carrier_detect_n(cdb_n), .chan_b_set_ready_n(srb_n), .other_irq(other_irq),
	.irq_n(irq_n), .uart_soft_reset(srst), .tx_disable(txd), .rx_disable(rxd),
	.ir_fast_pulse(irf), .baud_int(baud_int), .baud_frac(baud_frac), .oversample_sel(os),
	.tx_flow_sel(txf), .rx_flow_sel(rxf), .rx_either_pair(rxe), .rx_dual_seq(rxds),
	.tx_dual_seq(txds), .resume_char_first(rc1), .resume_char_second(rc2),
	.pause_char_first(pc1), .pause_char_second(pc2));
// ----------------------------------------
// Tasks
// ----------------------------------------
task chk(input [8*12:1] name, input [15:0] exp, input [15:0] got);
	begin
		tests_run = tests_run + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("ERROR %0s expected %h seen %h", name, exp, got);
		end
	end
endtask
task wrap_up;
	begin
		$display("Comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
endtask
task wr(input [3:0] a, input [7:0] d);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		#1;
	end
endtask
task rdc(input [3:0] a, input [7:0] e);
	begin
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1;
		chk("reg_rdata", e, reg_rdata);
	end
endtask
task wait_irq(input e);
	begin
		n = 0;
		while (irq_n !== e && n < 20) begin
			@(posedge sys_clk);
			#1;
			n = n + 1;
		end
		chk("irq_n", e, irq_n);
		if (irq_n !== e)
			wrap_up;
	end
endtask
task pins(input [7:0] v);
	begin
		@(posedge sys_clk);
		gpio_in <= v;
		repeat (5) @(posedge sys_clk);
		#1;
	end
endtask
// ----------------------------------------
// Clock and stimulus
// ----------------------------------------
initial begin
	sys_clk = 1'h0;
	forever #50 sys_clk = ~sys_clk;
end
initial begin
	{rstn, reg_wr, reg_rd, other_irq, reg_addr, reg_wdata, gpio_in} = 0;
	{tra_n, trb_n, miscompares, tests_run} = {1'h1, 1'h1, 64'h0};
	rows[0] = {`UGXC_A_DIR, 16'h5A5A};
	rows[1] = {`UGXC_A_IRQEN, 16'hC3C3};
	rows[2] = {`UGXC_A_EXTRA, 16'h8686};
	rows[3] = {`UGXC_A_DIVL, 16'h3434};
	rows[4] = {`UGXC_A_DIVH, 16'h1212};
	rows[5] = {`UGXC_A_FRAC, 16'h3F00};
	rows[6] = {`UGXC_A_ENH, 16'h1010};
	rows[7] = {`UGXC_A_FRAC, 16'hFF3F};
	rows[8] = {`UGXC_A_ENH, 16'h0000};
	rows[9] = {`UGXC_A_FRAC, 16'h0000};
	rows[10] = {`UGXC_A_RES1, 16'hA5A5};
	rows[11] = {`UGXC_A_PAU2, 16'h5A5A};
	rows[12] = {`UGXC_A_SCRATCH, 16'h7777};
	rows[13] = {4'hF, 16'hFF00};
	rows[14] = {`UGXC_A_STATUS, 16'hFF00};
	rows[15] = {`UGXC_A_RES2, 16'h3C3C};
	rows[16] = {`UGXC_A_PAU1, 16'hC3C3};
	repeat (12) @(posedge sys_clk);
	rstn <= 1'h1;
	for (i = 0; i < 17; i = i + 1) begin
		wr(rows[i][19:16], rows[i][15:8]);
		rdc(rows[i][19:16], rows[i][7:0]);
	end
	chk("divisor", 16'h1234, baud_int);
	chk("fraction", 16'h000F, baud_frac);
	chk("extra", 16'h075A, {irf, txd, rxd, rc1[3:0], pc2[3:0]});
	chk("chars", 16'h3CC3, {rc2, pc1});
	@(posedge sys_clk);
	rstn <= 1'h0;
	repeat (3) @(posedge sys_clk);
	rstn <= 1'h1;
	rdc(`UGXC_A_DIR, 8'h00);
	rdc(`UGXC_A_EXTRA, 8'h00);
	rdc(`UGXC_A_DIVL, 8'h34);
	for (i = 0; i < 4; i = i + 1) begin
		k = i;
		wr(`UGXC_A_ENH, 8'h10);
		wr(`UGXC_A_FRAC, {2'h0, k[1:0], 4'h5});
		chk("oversample", {k[1], ~k[1] & k[0], 4'h5}, {os, baud_frac});
	end
	for (i = 0; i < 16; i = i + 1) begin
		k = i;
		wr(`UGXC_A_ENH, 8'h10);
		wr(`UGXC_A_ENH, {4'h1, k});
		chk("flow", {k, k[3:2] == 2'h3, k[1:0] == 2'h3 && k[3] == k[2],
			k[1:0] == 2'h3 && k[3] != k[2]}, {txf, rxf, txds, rxds, rxe});
	end
	wr(`UGXC_A_DIR, 8'h00);
	wr(`UGXC_A_IRQEN, 8'h01);
	rdc(`UGXC_A_LEVEL, 8'h00);
	pins(8'h01);
	wait_irq(1'h0);
	pins(8'h00);
	wait_irq(1'h1);
	pins(8'h02);
	chk("irq_n", 16'h0001, irq_n);
	pins(8'h03);
	wait_irq(1'h0);
	rdc(`UGXC_A_LEVEL, 8'h03);
	wait_irq(1'h1);
	@(posedge sys_clk);
	other_irq <= 1'h1;
	@(posedge sys_clk);
	#1;
	chk("irq_n", 16'h0000, irq_n);
	@(posedge sys_clk);
	other_irq <= 1'h0;
	#1;
	chk("irq_n", 16'h0001, irq_n);
	wr(`UGXC_A_DIR, 8'hFF);
	wr(`UGXC_A_LEVEL, 8'hA5);
	chk("pins", 16'hFFA5, {gpio_oe, gpio_out});
	wr(`UGXC_A_DIR, 8'h22);
	pins(8'h00);
	rdc(`UGXC_A_LEVEL, 8'h00);
	wr(`UGXC_A_IRQEN, 8'hFF);
	wr(`UGXC_A_FUNC, 8'h02);
	tra_n <= 1'h0;
	pins(8'h40);
	chk("modem a", 16'h0005, {gpio_out[5], ria_n, cda_n, sra_n, irq_n});
	pins(8'h00);
	wr(`UGXC_A_FUNC, 8'h04);
	pins(8'h04);
	chk("modem b", 16'h0015, {gpio_out[1], rib_n, cdb_n, srb_n, irq_n});
	pins(8'h00);
	wr(`UGXC_A_FUNC, 8'h08);
	repeat (6) @(posedge sys_clk);
	rdc(`UGXC_A_FUNC, 8'h00);
	chk("kept", 16'h12A5, {baud_int[15:8], rc1});
	rdc(`UGXC_A_SCRATCH, 8'h77);
	wr(`UGXC_A_DIR, 8'h00);
	wr(`UGXC_A_IRQEN, 8'hFF);
	wr(`UGXC_A_FUNC, 8'h01);
	rdc(`UGXC_A_LEVEL, 8'h00);
	pins(8'h10);
	wait_irq(1'h0);
	pins(8'h00);
	chk("irq_n", 16'h0000, irq_n);
	rdc(`UGXC_A_LEVEL, 8'h10);
	wrap_up;
end
endmodule // ugxc_regs_bench
